// ===== rtl/emc_sync.sv
// Three-flop synchroniser with agreement filter.
// Assumes the pin idles high, asynchronous to ref_clk.
module emc_sync (
  input wire logic ref_clk,
  input wire logic rst,
  emc_sync_if.sync link
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic clean_r;

  // A change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      clean_r <= 1'b1;
    end else begin
      s1_r <= link.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        clean_r <= s3_r;
      end
    end
  end

  assign link.clean = clean_r;
endmodule

// ===== rtl/emc_top.sv
// Memory controller: SDRAM, PROM and I/O sequencing, config registers.
// Assumes one clock ref_clk, a synchronous reset and a single-beat register port.
// Overview of operation
// R1 - SDRAM chip size 4 MB to 512 MB from a 3-bit field.
// R2 - 8 to 12 column bits, 13 row bits, four banks, 32-bit data.
// R3 - Row and column on address 14:2, bank on 16:15.
// R4 - CAS, precharge, refresh period and interval programmable.
// R5 - Command field issues precharge, refresh or mode load, then clears.
// R6 - Mode load: page read burst, single write, sequential, CAS.
// R7 - CAS bit picks latency 2 or 3; change it with mode load.
// R8 - Mode address: 11,7,4,3,2 high, 6 is CAS bit, rest low.
// R9 - Refresh enable: periodic refresh to both chips at once.
// R10 - Refresh period is reload value plus one.
// R11 - Enable runs precharge, two refreshes, mode load on both chips.
// R12 - Access: activate, CAS wait, read or write, precharge.
// R13 - Bus burst gives burst read and back-to-back writes.
// R14 - Two PROM selects for low and high 256 MB halves.
// R15 - PROM read and write waits 0 to 31; write gate; width.
// R16 - 8, 16, 32-bit devices on top byte, top half, whole bus.
// R17 - Read lead-out drives the previous cycle's bus address.
// R18 - Upper I/O half aliases the lower half.
// R19 - I/O width 00 byte, 01 half, 1x word; same cycle shape.
// R20 - Software uses matching-size loads and stores on narrow I/O.
// R21 - I/O strobes stretched by up to 15 wait cycles.
// R22 - With ready on, strobe ends a clock after ready low; here it ends two clocks after the filtered ready_clean falls.
// R23 - Refresh counter reloads on expiry; due refresh waits for precharge.
module emc_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  input wire logic bus_write,
  input wire logic bus_burst,
  input wire logic [3:0] bus_strb,
  input wire logic [31:0] bus_wdata,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  output logic [27:0] mem_addr,
  input wire logic [31:0] mem_data_in,
  output logic [31:0] mem_data_out,
  output logic mem_data_oe_n,
  output logic boot_rom_select_lo_n,
  output logic boot_rom_select_hi_n,
  output logic periph_select_n,
  output logic output_enable_n,
  output logic mem_write_n,
  input wire logic ready_n,
  output logic [1:0] sdram_chip_select_n,
  output logic sdram_row_strobe_n,
  output logic sdram_col_strobe_n,
  output logic sdram_write_en_n,
  output logic [3:0] sdram_byte_mask
);
  import emc_pkg::*;
  `include "emc_defs.svh"

  logic [31:0] prom_io_config_reg_r;
  logic [31:0] ram_config_reg_r;
  logic [31:0] sdram_config_reg_r;
  logic [31:0] reg_rdata_r;
  emc_state_t state_r;
  logic [4:0] cnt_r;
  logic [1:0] seq_r;
  logic in_init_r;
  logic sd_en_prev_r;
  logic init_pend_r;
  logic [14:0] ref_cnt_r;
  logic refresh_due_r;
  logic acc_wr_r;
  logic acc_io_r;
  logic [1:0] acc_cs_n_r;
  logic [11:0] col_r;
  logic [27:0] mem_addr_r;
  logic [31:0] mem_dout_r;
  logic mem_doe_n_r;
  logic rom_lo_n_r;
  logic rom_hi_n_r;
  logic io_n_r;
  logic oe_n_r;
  logic wr_n_r;
  logic [1:0] sd_cs_n_r;
  logic [2:0] sd_cmd_r;
  logic [3:0] sd_mask_r;
  logic bus_ack_r;
  logic [31:0] bus_rdata_r;
  logic ready_clean;
  emc_sync_if rdy_if ();

  // Decoded configuration
  logic sd_en;
  logic refresh_enable;
  logic [1:0] sd_cmd;
  logic [4:0] cas_delay;
  logic [4:0] precharge_to_activate;
  logic [4:0] refresh_cmd_period;
  logic [3:0] col_bits;
  logic [26:0] word_w;
  logic [12:0] row_w;
  logic [1:0] bank_w;
  logic [11:0] col_w;
  logic [1:0] cs_n_w;
  logic hit_rom;
  logic hit_io;
  logic hit_sd;
  emc_width_t width_w;
  logic [31:0] lane_wdata;
  logic [31:0] lane_rdata;
  logic [3:0] periph_wait_states;
  logic [4:0] strobe_ws;

  assign sd_en = ram_config_reg_r[`EMC_B_SD_EN];
  assign refresh_enable = ram_config_reg_r[`EMC_B_REF_EN];
  assign sd_cmd = ram_config_reg_r[`EMC_F_SD_CMD];
  assign cas_delay = ram_config_reg_r[`EMC_B_CAS_SEL] ? 5'h03 : 5'h02; // [R4] [R7]
  assign precharge_to_activate = sdram_config_reg_r[`EMC_B_TRP_SEL] ? 5'h03 : 5'h02; // [R4]
  assign refresh_cmd_period = `EMC_REFRESH_CMD_PERIOD_BASE + {1'b0, sdram_config_reg_r[`EMC_F_REF_PERIOD]};
  assign col_bits = `EMC_COL_BASE + {1'b0, sdram_config_reg_r[`EMC_F_COL_BITS]}; // [R2]

  // Column, row and bank by column width
  assign word_w = bus_addr[28:2];
  assign row_w = 13'(word_w >> col_bits); // [R2]
  assign bank_w = 2'(word_w >> (5'(col_bits) + 5'h0D));
  assign col_w = 12'(word_w) & ~(12'hFFF << col_bits);
  // Chip select: address bit 22 plus size field
  assign cs_n_w = bus_addr[`EMC_SIZE_BASE_BIT + {2'h0, ram_config_reg_r[`EMC_F_SD_BANK_SIZE]}]
                  ? 2'h1 : 2'h2; // [R1]

  // Region decode; I/O ignores bit 28 so halves alias
  assign hit_rom = (bus_addr[31:29] == 3'h0); // [R14]
  assign hit_io = (bus_addr[31:29] == 3'h1); // [R18]
  assign hit_sd = (bus_addr[31:29] == 3'h3) && sd_en;
  assign periph_wait_states = prom_io_config_reg_r[`EMC_F_IO_WS];
  assign strobe_ws = acc_io_r ? {1'b0, periph_wait_states} :
                     acc_wr_r ? prom_io_config_reg_r[`EMC_F_PROM_WR_WS] :
                     prom_io_config_reg_r[`EMC_F_PROM_RD_WS]; // [R15] [R21]

  // Lane steering; cycle shape is width independent
  always_comb begin
    logic [1:0] wsel;
    wsel = acc_io_r ? prom_io_config_reg_r[`EMC_F_IO_WIDTH] : prom_io_config_reg_r[`EMC_F_PROM_WIDTH];
    width_w = wsel[1] ? W32 : (wsel[0] ? W16 : W8); // [R19]
    lane_wdata = bus_wdata;
    lane_rdata = mem_data_in;
    if (width_w == W8) begin
      lane_wdata = {4{bus_wdata[8'(31 - 8 * bus_addr[1:0]) -: 8]}}; // [R16]
      lane_rdata = {4{mem_data_in[31:24]}};
    end else if (width_w == W16) begin
      lane_wdata = bus_addr[1] ? {2{bus_wdata[15:0]}} : {2{bus_wdata[31:16]}}; // [R16]
      lane_rdata = {2{mem_data_in[31:16]}};
    end
  end

  // Ready passes the three-flop filter
  assign rdy_if.raw = ready_n;
  assign ready_clean = rdy_if.clean;
  emc_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .link(rdy_if.sync)
  );

  // Register writes; software beats the command clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prom_io_config_reg_r <= `EMC_RST_PROM_IO;
      ram_config_reg_r <= `EMC_RST_RAM;
      sdram_config_reg_r <= `EMC_RST_SDRAM;
    end else begin
      if (reg_wr && reg_addr == `EMC_OFS_PROM_IO) begin
        prom_io_config_reg_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `EMC_OFS_RAM) begin
        ram_config_reg_r <= reg_wdata;
      end else if (state_r == ST_IDLE && !init_pend_r && sd_cmd != 2'h0) begin
        ram_config_reg_r[`EMC_F_SD_CMD] <= 2'h0; // [R5]
      end
      if (reg_wr && reg_addr == `EMC_OFS_SDRAM) begin
        sdram_config_reg_r <= reg_wdata;
      end
    end
  end

  // Read data stand for exactly one cycle; unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata_r <= 32'h00000000;
    end else begin
      reg_rdata_r <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `EMC_OFS_PROM_IO: reg_rdata_r <= prom_io_config_reg_r;
          `EMC_OFS_RAM: reg_rdata_r <= ram_config_reg_r;
          `EMC_OFS_SDRAM: reg_rdata_r <= sdram_config_reg_r;
          `EMC_OFS_STATUS: reg_rdata_r <= {24'h0, state_r, in_init_r, init_pend_r,
                                           refresh_due_r, ready_clean};
          default: reg_rdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // Enable edge arms init; edge wins over clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sd_en_prev_r <= 1'b0;
      init_pend_r <= 1'b0;
    end else begin
      sd_en_prev_r <= sd_en;
      if (sd_en && !sd_en_prev_r) begin
        init_pend_r <= 1'b1; // [R11]
      end else if (state_r == ST_IDLE) begin
        init_pend_r <= 1'b0;
      end
    end
  end

  // Refresh timer; expiry wins over the due clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_cnt_r <= 15'h0000;
      refresh_due_r <= 1'b0;
    end else begin
      if (!refresh_enable || ref_cnt_r == 15'h0000) begin
        ref_cnt_r <= sdram_config_reg_r[`EMC_F_REF_RELOAD]; // [R10] [R23]
      end else begin
        ref_cnt_r <= ref_cnt_r - 15'h0001;
      end
      if (refresh_enable && ref_cnt_r == 15'h0000) begin
        refresh_due_r <= 1'b1; // [R9]
      end else if (state_r == ST_REF) begin
        refresh_due_r <= 1'b0;
      end
    end
  end

  // Main sequencer; all pins from flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      seq_r <= 2'h0;
      in_init_r <= 1'b0;
      acc_wr_r <= 1'b0;
      acc_io_r <= 1'b0;
      acc_cs_n_r <= 2'h3;
      col_r <= 12'h000;
      mem_addr_r <= 28'h0000000;
      mem_dout_r <= 32'h00000000;
      mem_doe_n_r <= 1'b1;
      rom_lo_n_r <= 1'b1;
      rom_hi_n_r <= 1'b1;
      io_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      sd_cs_n_r <= 2'h3;
      sd_cmd_r <= `EMC_SD_NOP;
      sd_mask_r <= 4'hF;
      bus_ack_r <= 1'b0;
      bus_rdata_r <= 32'h00000000;
    end else begin
      sd_cmd_r <= `EMC_SD_NOP;
      sd_cs_n_r <= 2'h3;
      sd_mask_r <= 4'hF;
      bus_ack_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          mem_doe_n_r <= 1'b1;
          acc_cs_n_r <= 2'h0;
          // Housekeeping goes first at idle; a due refresh still waits for a burst stream to end
          if (init_pend_r) begin
            in_init_r <= 1'b1; // [R11]
            seq_r <= 2'h0;
            state_r <= ST_PRE;
          end else if (sd_cmd == `EMC_CMD_PRE) begin
            state_r <= ST_PRE; // [R5]
          end else if (sd_cmd == `EMC_CMD_REF) begin
            state_r <= ST_REF; // [R5]
          end else if (sd_cmd == `EMC_CMD_LMR) begin
            state_r <= ST_LMR; // [R5]
          end else if (refresh_due_r && refresh_enable) begin
            state_r <= ST_REF; // [R9] [R23]
          end else if (bus_ack_r) begin
            // The ack edge still shows the old request; skip it
          end else if (bus_req && hit_sd) begin
            acc_wr_r <= bus_write;
            acc_cs_n_r <= cs_n_w;
            col_r <= col_w;
            state_r <= ST_ACT;
          end else if (bus_req && (hit_rom || hit_io)) begin
            acc_wr_r <= bus_write;
            acc_io_r <= hit_io;
            if (bus_write && hit_rom && !prom_io_config_reg_r[`EMC_B_PROM_WR_EN]) begin
              bus_ack_r <= 1'b1; // [R15] Gated write completes without a strobe
            end else begin
              mem_addr_r <= bus_addr[27:0]; // [R16]
              rom_lo_n_r <= !(hit_rom && !bus_addr[28]); // [R14]
              rom_hi_n_r <= !(hit_rom && bus_addr[28]);
              io_n_r <= !hit_io; // [R18]
              mem_dout_r <= lane_wdata;
              mem_doe_n_r <= !bus_write;
              state_r <= ST_LEAD;
            end
          end else if (bus_req) begin
            bus_ack_r <= 1'b1; // Unmapped or disabled space answers zero
            bus_rdata_r <= 32'h00000000;
          end
        end
        ST_ACT: begin
          sd_cmd_r <= `EMC_SD_ACT; // [R12]
          sd_cs_n_r <= acc_cs_n_r;
          mem_addr_r <= {11'h000, bank_w, row_w, 2'h0}; // [R3]
          cnt_r <= cas_delay - 5'h02;
          state_r <= ST_RCD;
        end
        ST_RCD: begin
          cnt_r <= cnt_r - 5'h01;
          if (cnt_r == 5'h00) begin
            state_r <= ST_RW; // [R12]
            bus_ack_r <= acc_wr_r; // Write beats acked one cycle ahead [R13]
          end
        end
        ST_RW: begin
          sd_cs_n_r <= acc_cs_n_r;
          mem_addr_r <= {11'h000, bank_w, col_r[11:10], 1'b0, col_r[9:0], 2'h0}; // [R3]
          if (acc_wr_r) begin
            // Each beat is its own write command, so a burst has no idle slot
            sd_cmd_r <= `EMC_SD_WR; // [R13]
            sd_mask_r <= ~bus_strb;
            mem_dout_r <= bus_wdata;
            mem_doe_n_r <= 1'b0;
            bus_ack_r <= bus_burst;
            col_r <= col_r + 12'h001;
            if (!bus_burst) begin
              state_r <= ST_PRE;
            end
          end else begin
            sd_cmd_r <= `EMC_SD_RD; // [R13]
            sd_mask_r <= 4'h0;
            cnt_r <= cas_delay;
            state_r <= ST_CAS;
          end
        end
        ST_CAS: begin
          sd_mask_r <= 4'h0;
          if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
          end else begin
            // Precharge cuts the page burst
            bus_ack_r <= 1'b1;
            bus_rdata_r <= mem_data_in;
            if (!bus_burst) begin
              state_r <= ST_PRE; // [R13]
            end
          end
        end
        ST_PRE: begin
          sd_cmd_r <= `EMC_SD_PRE; // [R12]
          sd_cs_n_r <= acc_cs_n_r;
          mem_doe_n_r <= 1'b1;
          mem_addr_r <= 28'h0000000;
          mem_addr_r[`EMC_PRE_ALL_BIT] <= 1'b1;
          cnt_r <= precharge_to_activate - 5'h02; // [R4]
          state_r <= ST_WAIT;
        end
        ST_REF: begin
          sd_cmd_r <= `EMC_SD_REF; // [R9]
          sd_cs_n_r <= 2'h0;
          cnt_r <= refresh_cmd_period - 5'h02; // [R4]
          state_r <= ST_WAIT;
        end
        ST_LMR: begin
          sd_cmd_r <= `EMC_SD_LMR; // [R6]
          sd_cs_n_r <= 2'h0;
          mem_addr_r <= `EMC_LMR_ADDR; // [R8]
          mem_addr_r[`EMC_LMR_CAS_BIT] <= ram_config_reg_r[`EMC_B_CAS_SEL]; // [R7] [R8]
          cnt_r <= precharge_to_activate - 5'h02;
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          cnt_r <= cnt_r - 5'h01;
          if (cnt_r == 5'h00) begin
            if (in_init_r && seq_r != 2'h3) begin
              seq_r <= seq_r + 2'h1;
              state_r <= (seq_r == 2'h2) ? ST_LMR : ST_REF; // [R11]
            end else begin
              in_init_r <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_LEAD: begin
          oe_n_r <= acc_wr_r;
          wr_n_r <= !acc_wr_r;
          cnt_r <= strobe_ws;
          state_r <= ST_STROBE;
        end
        ST_STROBE: begin
          if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01; // [R15] [R21]
          end else if (acc_io_r && prom_io_config_reg_r[`EMC_B_READY_EN]) begin
            state_r <= ST_READY; // [R22]
          end else begin
            state_r <= ST_TAIL;
          end
        end
        ST_READY: begin
          if (!ready_clean) begin
            state_r <= ST_TAIL; // [R22]
          end
        end
        ST_TAIL: begin
          oe_n_r <= 1'b1;
          wr_n_r <= 1'b1;
          rom_lo_n_r <= 1'b1;
          rom_hi_n_r <= 1'b1;
          io_n_r <= 1'b1;
          mem_doe_n_r <= 1'b1;
          bus_ack_r <= 1'b1;
          bus_rdata_r <= lane_rdata; // [R16] [R19]
          state_r <= acc_wr_r ? ST_IDLE : ST_OUT;
        end
        ST_OUT: begin
          // Lead-out shows the previous cycle's bus address
          mem_addr_r <= bus_addr[27:0]; // [R17]
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign bus_ack = bus_ack_r;
  assign bus_rdata = bus_rdata_r;
  assign mem_addr = mem_addr_r;
  assign mem_data_out = mem_dout_r;
  assign mem_data_oe_n = mem_doe_n_r;
  assign boot_rom_select_lo_n = rom_lo_n_r;
  assign boot_rom_select_hi_n = rom_hi_n_r;
  assign periph_select_n = io_n_r;
  assign output_enable_n = oe_n_r;
  assign mem_write_n = wr_n_r;
  assign sdram_chip_select_n = sd_cs_n_r;
  assign {sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_en_n} = sd_cmd_r;
  assign sdram_byte_mask = sd_mask_r;
endmodule

// ===== shared/emc_defs.svh
// Memory controller offsets, fields, resets and timings.
// Assumes a 32-bit word register port.
`ifndef EMC_DEFS_SVH
`define EMC_DEFS_SVH
`define EMC_OFS_PROM_IO 8'h00
`define EMC_OFS_RAM 8'h04
`define EMC_OFS_SDRAM 8'h08
`define EMC_OFS_STATUS 8'h0C
`define EMC_RST_PROM_IO 32'h0001F01F
`define EMC_RST_RAM 32'h00000000
`define EMC_RST_SDRAM 32'h00000000
`define EMC_F_PROM_RD_WS 4:0
`define EMC_F_PROM_WIDTH 9:8
`define EMC_B_PROM_WR_EN 11
`define EMC_F_PROM_WR_WS 16:12
`define EMC_F_IO_WS 23:20
`define EMC_B_READY_EN 26
`define EMC_F_IO_WIDTH 28:27
`define EMC_B_SD_EN 14
`define EMC_F_SD_CMD 20:19
`define EMC_F_SD_BANK_SIZE 25:23
`define EMC_B_CAS_SEL 26
`define EMC_B_REF_EN 31
`define EMC_F_COL_BITS 2:0
`define EMC_F_REF_RELOAD 26:12
`define EMC_F_REF_PERIOD 30:27
`define EMC_B_TRP_SEL 31
`define EMC_COL_BASE 4'h8
`define EMC_SIZE_BASE_BIT 5'h16
`define EMC_REFRESH_CMD_PERIOD_BASE 5'h03
`define EMC_CMD_PRE 2'h1
`define EMC_CMD_REF 2'h2
`define EMC_CMD_LMR 2'h3
`define EMC_SD_NOP 3'h7
`define EMC_SD_ACT 3'h3
`define EMC_SD_RD 3'h5
`define EMC_SD_WR 3'h4
`define EMC_SD_PRE 3'h2
`define EMC_SD_REF 3'h1
`define EMC_SD_LMR 3'h0
`define EMC_LMR_ADDR 28'h000089C
`define EMC_LMR_CAS_BIT 6
`define EMC_PRE_ALL_BIT 12
`endif

// ===== shared/emc_pkg.sv
// Types shared by the memory controller modules.
// Assumes emc_defs.svh carries every number.
package emc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ACT, ST_RCD, ST_RW, ST_CAS, ST_PRE, ST_WAIT, ST_REF, ST_LMR,
    ST_LEAD, ST_STROBE, ST_READY, ST_TAIL, ST_OUT
  } emc_state_t;
  typedef enum logic [1:0] {W8, W16, W32} emc_width_t;
endpackage

// ===== shared/emc_sync_if.sv
// One pin level in, filtered level out.
// Assumes both ends on ref_clk.
interface emc_sync_if;
  logic raw;
  logic clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ===== test/emc_mem_model.sv
// Far side: PROM and I/O data plus I/O ready.
// Assumes ready has a pull-up; link clock unrelated to ref_clk.
module emc_mem_model (
  input wire logic [27:0] mem_addr,
  input wire logic output_enable_n,
  input wire logic mem_write_n,
  input wire logic periph_select_n,
  input wire logic [7:0] ready_delay,
  output logic [31:0] mem_data_in,
  output logic ready_n = 1'h1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lclk = 1'h0;
  logic [31:0] last = 32'h0;
  int t = 0;
  // Link clock at 200 ns, started off phase
  initial #37 forever #100 lclk = ~lclk;
  // Released bus shows the inverse, so stale data fails
  always @(output_enable_n, mem_addr) begin
    if (!output_enable_n) last = {4'hA, mem_addr};
  end
  assign mem_data_in = output_enable_n ? ~last : last;
  // Ready falls some link ticks into a strobe; pulled up after
  always @(posedge lclk) begin
    if (periph_select_n || (output_enable_n && mem_write_n)) begin
      t <= 0;
      ready_n <= 1'h1;
    end else begin
      t <= t + 1;
      if (t >= ready_delay) ready_n <= 1'h0;
    end
  end
endmodule

// ===== test/emc_top_bench.sv
// Self-checking bench for emc_top.
// Assumes emc_mem_model on the pins, checker bound in.
`include "emc_defs.svh"
module emc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic bus_req = 1'h0, bus_write = 1'h0, bus_burst = 1'h0, wr_prev = 1'h0, lo, hi, io, wl;
  logic [7:0] reg_addr = 8'h00, rdy_dly = 8'hC8;
  logic [31:0] reg_wdata = 32'h0, bus_addr = 32'h0, bus_wdata = 32'h0, got, base, wd;
  logic [31:0] reg_rdata, bus_rdata, mem_data_in, mem_data_out;
  logic [3:0] bus_strb = 4'hF, sdram_byte_mask;
  logic [27:0] mem_addr, lmr_a;
  logic [1:0] sdram_chip_select_n;
  logic [2:0] cmd;
  logic bus_ack, mem_data_oe_n, boot_rom_select_lo_n, boot_rom_select_hi_n, periph_select_n;
  logic output_enable_n, mem_write_n, ready_n, sdram_row_strobe_n, sdram_col_strobe_n;
  logic sdram_write_en_n, sd_on;
  int err_total = 0, n_tests = 0, cyc = 0, last_ref = 0, gap = 0, b2b = 0, n, cnt[8], snap[8];
  assign cmd = {sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_en_n};
  assign sd_on = sdram_chip_select_n != 2'h3;
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  emc_top dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_req,
    .bus_addr, .bus_write, .bus_burst, .bus_strb, .bus_wdata, .bus_ack, .bus_rdata, .mem_addr,
    .mem_data_in, .mem_data_out, .mem_data_oe_n, .boot_rom_select_lo_n, .boot_rom_select_hi_n,
    .periph_select_n, .output_enable_n, .mem_write_n, .ready_n, .sdram_chip_select_n,
    .sdram_row_strobe_n, .sdram_col_strobe_n, .sdram_write_en_n, .sdram_byte_mask);
  emc_mem_model far (.mem_addr, .output_enable_n, .mem_write_n, .periph_select_n,
    .ready_delay(rdy_dly), .mem_data_in, .ready_n);
  // Tally SDRAM commands
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    wr_prev <= sd_on && cmd == `EMC_SD_WR;
    if (wr_prev && sd_on && cmd == `EMC_SD_WR) b2b <= b2b + 1;
    if (!rst && sd_on) begin
      cnt[cmd] <= cnt[cmd] + 1;
      if (cmd == `EMC_SD_LMR) lmr_a <= mem_addr;
      if (cmd == `EMC_SD_REF) begin
        gap <= cyc - last_ref;
        last_ref <= cyc;
      end
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(posedge ref_clk);
    chk(reg_rdata, e);
  endtask
  // One beat; req stays up between burst beats
  task automatic acc(input logic [31:0] a, input logic w, input logic bst);
    bus_req <= 1'h1;
    bus_addr <= a;
    bus_write <= w;
    bus_burst <= bst;
    bus_wdata <= ~a;
    {lo, hi, io, wl} = 4'h0;
    for (n = 1; n < 300; n++) begin
      @(posedge ref_clk);
      lo |= !boot_rom_select_lo_n;
      hi |= !boot_rom_select_hi_n;
      io |= !periph_select_n;
      wl |= !mem_write_n;
      if (!mem_write_n) wd = mem_data_out;
      if (bus_ack === 1'h1) break;
    end
    got = bus_rdata;
    if (n == 300) begin
      err_total++;
      finish_test();
    end
    if (!bst) begin
      bus_req <= 1'h0;
      @(posedge ref_clk);
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    // Reset values, unmapped offset
    rd(`EMC_OFS_PROM_IO, `EMC_RST_PROM_IO);
    rd(`EMC_OFS_RAM, `EMC_RST_RAM);
    rd(`EMC_OFS_SDRAM, `EMC_RST_SDRAM);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    $display("test registers done");
    // PROM waits and selects
    for (int ws = 0; ws < 4; ws += 3) begin
      wr(`EMC_OFS_PROM_IO, 32'h00000200 | ws);
      acc(32'h00000010, 1'h0, 1'h0);
      chk(n, 5 + ws);
      chk(got, 32'hA0000010);
      chk({lo, hi}, 2'h2);
    end
    acc(32'h10000010, 1'h0, 1'h0);
    chk({lo, hi}, 2'h1);
    acc(32'h00000020, 1'h1, 1'h0);
    chk({wl, n[3:0]}, 5'h02);
    wr(`EMC_OFS_PROM_IO, 32'h00000A00);
    acc(32'h00000020, 1'h1, 1'h0);
    chk(wl, 1'h1);
    chk(wd, 32'hFFFFFFDF);
    $display("test prom done");
    // I/O widths and alias
    for (int w = 0; w < 3; w++) begin
      wr(`EMC_OFS_PROM_IO, w << 27);
      acc(w[0] ? 32'h20000010 : 32'h30000010, 1'h0, 1'h0);
      chk(got, w == 0 ? 32'hA0A0A0A0 : w == 1 ? 32'hA000A000 : 32'hA0000010);
      chk({io, n[7:0]}, 9'h105);
    end
    // Stretch, slow and prompt ready
    wr(`EMC_OFS_PROM_IO, 32'h10200000);
    acc(32'h20000020, 1'h0, 1'h0);
    chk(n, 7);
    wr(`EMC_OFS_PROM_IO, 32'h14200000);
    rdy_dly <= 8'h06;
    acc(32'h20000020, 1'h0, 1'h0);
    chk(n >= 49 && n <= 80, 1'h1);
    rdy_dly <= 8'h00;
    repeat (30) @(posedge ref_clk);
    acc(32'h20000020, 1'h0, 1'h0);
    chk(n >= 7 && n <= 26, 1'h1);
    $display("test io done");
    // SDRAM init and commands
    wr(`EMC_OFS_RAM, 32'h00004000);
    repeat (100) @(posedge ref_clk);
    chk(cnt[`EMC_SD_PRE] * 16 + cnt[`EMC_SD_REF] * 4 + cnt[`EMC_SD_LMR], 25);
    for (int c = 1; c < 4; c++) begin
      snap = cnt;
      base = c == 3 ? 32'h04004000 : 32'h00004000;
      wr(`EMC_OFS_RAM, base | (c << 19));
      repeat (30) @(posedge ref_clk);
      rd(`EMC_OFS_RAM, base);
      chk(cnt[3 - c] - snap[3 - c], 1);
    end
    chk(lmr_a, 28'h00008DC);
    $display("test sdram setup done");
    // Burst write, single read
    snap = cnt;
    acc(32'h60000100, 1'h1, 1'h1);
    acc(32'h60000104, 1'h1, 1'h0);
    acc(32'h60000100, 1'h0, 1'h0);
    repeat (20) @(posedge ref_clk);
    chk(b2b, 1);
    chk(cnt[`EMC_SD_ACT] - snap[`EMC_SD_ACT], 2);
    chk(cnt[`EMC_SD_PRE] - snap[`EMC_SD_PRE], 2);
    chk(cnt[`EMC_SD_RD] - snap[`EMC_SD_RD], 1);
    // Refresh spacing
    wr(`EMC_OFS_SDRAM, 32'h00014000);
    wr(`EMC_OFS_RAM, 32'h84004000);
    repeat (100) @(posedge ref_clk);
    chk(gap, 21);
    acc(32'h60000200, 1'h0, 1'h0);
    repeat (80) @(posedge ref_clk);
    chk(gap, 21);
    $display("test sdram access done");
    finish_test();
  end
endmodule

// ===== test/emc_top_checker.sv
// Pin checks, bound into emc_top.
// Assumes a synchronous active-high reset.
`include "emc_defs.svh"
module emc_top_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bus_ack,
  input wire logic [31:0] bus_addr,
  input wire logic [27:0] mem_addr,
  input wire logic output_enable_n,
  input wire logic boot_rom_select_lo_n,
  input wire logic boot_rom_select_hi_n,
  input wire logic mem_data_oe_n,
  input wire logic [1:0] sdram_chip_select_n,
  input wire logic sdram_row_strobe_n,
  input wire logic sdram_col_strobe_n,
  input wire logic sdram_write_en_n,
  input wire logic [3:0] sdram_byte_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cmd;
  logic sel;
  // Command code
  assign cmd = {sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_en_n};
  assign sel = sdram_chip_select_n != 2'h3;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_act; sel && cmd == `EMC_SD_ACT; endsequence
  sequence s_rw; sel && (cmd == `EMC_SD_RD || cmd == `EMC_SD_WR); endsequence
  sequence s_lmr; sel && cmd == `EMC_SD_LMR; endsequence
  sequence s_lead; $rose(output_enable_n) && bus_ack; endsequence
  property p_act_rw; s_act |-> ##[1:4] s_rw; endproperty
  property p_lmr_addr; s_lmr |-> (mem_addr & ~28'h0000040) == `EMC_LMR_ADDR; endproperty
  property p_lmr_both; s_lmr |-> sdram_chip_select_n == 2'h0; endproperty
  property p_ref_both; sel && cmd == `EMC_SD_REF |-> sdram_chip_select_n == 2'h0; endproperty
  property p_rd_mask; sel && cmd == `EMC_SD_RD |-> sdram_byte_mask == 4'h0; endproperty
  property p_wr_drive; sel && cmd == `EMC_SD_WR |-> !mem_data_oe_n; endproperty
  property p_oe_len; $fell(output_enable_n) |-> !output_enable_n [*2]; endproperty
  property p_lead_out; s_lead |=> ##1 mem_addr == 28'($past(bus_addr)); endproperty
  property p_rom_excl; !boot_rom_select_hi_n |-> boot_rom_select_lo_n; endproperty
  a_act_rw: assert property (p_act_rw) else $error("no access after activate");
  a_lmr_addr: assert property (p_lmr_addr) else $error("mode address wrong");
  a_lmr_both: assert property (p_lmr_both) else $error("mode load on one chip");
  a_ref_both: assert property (p_ref_both) else $error("refresh on one chip");
  a_rd_mask: assert property (p_rd_mask) else $error("mask set on read");
  a_wr_drive: assert property (p_wr_drive) else $error("data not driven on write");
  a_oe_len: assert property (p_oe_len) else $error("read strobe too short");
  a_lead_out: assert property (p_lead_out) else $error("lead-out address wrong");
  a_rom_excl: assert property (p_rom_excl) else $error("both PROM selects low");
endmodule
bind emc_top emc_top_checker chk_i (.ref_clk, .rst, .bus_ack, .bus_addr, .mem_addr,
  .output_enable_n, .boot_rom_select_lo_n, .boot_rom_select_hi_n, .mem_data_oe_n,
  .sdram_chip_select_n, .sdram_row_strobe_n, .sdram_col_strobe_n, .sdram_write_en_n,
  .sdram_byte_mask);
